// ===== board_power_reset_sequencer_test.sv
// Purpose: self-checking bench for the sequencer
// Assumes: counts shortened to 50 and 4
// Notes: bounds allow a few cycles of sync slack
`default_nettype none
module board_power_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 0, RESET_N = 0, POWER_BUTTON_ON = 0, INPUT_SUPPLY_OK = 0, MODULE_RAILS_GOOD = 0, OVERVOLTAGE = 0;
  logic PRESS = 0;
  wire EXT_RESET_REQ_N, POINT_OF_LOAD_REGULATOR_EN, TRACKING_REGULATOR_EN, CPU_RESET_N_O, CPU_RESET_N_OE_N;
  wire GLOBAL_RESET_OUT_N, CPU_POWERON_RESET_N, STORAGE_RESET_N, MEMBANK0_RESET_N, MEMBANK1_RESET_N;
  wire OVERVOLTAGE_FAULT, CPU_RESET_WIRE_N;
  int mismatches = 0, tests_run = 0, cyc = 0, n;
  bprs_sequencer #(.RESET_CYCLES(25'h32), .DEBOUNCE_CYCLES(25'h4)) uut (.*);
  bprs_partner far (.*);
  initial forever #2 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input logic seen, input logic exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge MCLK);
    #1;
  endtask
  task automatic wait_up;
    for (n = 0; GLOBAL_RESET_OUT_N !== 1'h1 && n < 300; n++) tick(1);
  endtask
  task automatic t_power_up;
    @(posedge MCLK) POWER_BUTTON_ON <= 1'h1;
    tick(5);
    check(POINT_OF_LOAD_REGULATOR_EN, 1'h0, "early regs");
    @(posedge MCLK) INPUT_SUPPLY_OK <= 1'h1;
    tick(3);
    check(POINT_OF_LOAD_REGULATOR_EN & TRACKING_REGULATOR_EN, 1'h1, "regs off");
    tick(80);
    check(GLOBAL_RESET_OUT_N | CPU_POWERON_RESET_N, 1'h0, "early release");
    @(posedge MCLK) MODULE_RAILS_GOOD <= 1'h1;
    wait_up();
    check(n >= 50 && n < 60, 1'h1, "reset length");
    check(CPU_RESET_WIRE_N & STORAGE_RESET_N & MEMBANK0_RESET_N & MEMBANK1_RESET_N, 1'h1, "held");
    check(CPU_POWERON_RESET_N, 1'h1, "config");
    $display("power up test done");
  endtask
  task automatic t_key(input int hold, input int lo, input int hi);
    @(posedge MCLK) PRESS <= 1'h1;
    tick(hold);
    check(GLOBAL_RESET_OUT_N | CPU_RESET_WIRE_N, 1'h0, "key ignored");
    check(STORAGE_RESET_N | MEMBANK0_RESET_N | MEMBANK1_RESET_N | CPU_RESET_N_O, 1'h0, "periph free");
    @(posedge MCLK) PRESS <= 1'h0;
    wait_up();
    check(n >= lo && n < hi, 1'h1, "key reset length");
    $display("key test done");
  endtask
  task automatic t_fault;
    @(posedge MCLK) OVERVOLTAGE <= 1'h1;
    tick(2);
    check(POINT_OF_LOAD_REGULATOR_EN | GLOBAL_RESET_OUT_N, 1'h0, "regs on");
    check(OVERVOLTAGE_FAULT, 1'h1, "no fault");
    @(posedge MCLK) OVERVOLTAGE <= 1'h0;
    tick(3);
    check(TRACKING_REGULATOR_EN, 1'h0, "fault dropped");
    @(posedge MCLK) POWER_BUTTON_ON <= 1'h0;
    tick(3);
    check(OVERVOLTAGE_FAULT | CPU_POWERON_RESET_N, 1'h0, "still on");
    $display("fault test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(10);
    @(posedge MCLK) RESET_N <= 1'h1;
    t_power_up();
    t_key(120, 0, 14);
    t_key(12, 38, 56);
    t_fault();
    final_report();
  end
endmodule
`default_nettype wire

// ===== bprs_consts.vh
// Overview of operation
// - Check input supply before enabling any regulator
// - Then enable point-of-load and tracking regulators together
// - Reset sequence waits for all rails good
// - Release processor reset 100 ms later
// - Low external request extends the reset
// - Falling request edge restarts at least 100 ms
// - Global reset output follows processor reset
// - Overvoltage disables all point-of-load regulators
// - Latched button position sets rails on/off
// - All resets are active low
// - Processor reset open drain, others driven
//
// Purpose: constants for the board power and reset sequencer
// Assumes: MCLK at 250 MHz
// Notes: long counts are module parameters so simulation can shorten them
`ifndef BPRS_CONSTS_VH
`define BPRS_CONSTS_VH
`define BPRS_CLK_MHZ 250
`define BPRS_RESET_MS 100
`define BPRS_RESET_CYCLES (`BPRS_RESET_MS * 1000 * `BPRS_CLK_MHZ)
`define BPRS_DEBOUNCE_US 1000
`define BPRS_DEBOUNCE_CYCLES (`BPRS_DEBOUNCE_US * `BPRS_CLK_MHZ)
`define BPRS_CNT_W 25
`define BPRS_ST_W 3
`define BPRS_ST_OFF 3'h0
`define BPRS_ST_CHECK 3'h1
`define BPRS_ST_RAMP 3'h2
`define BPRS_ST_RESET 3'h3
`define BPRS_ST_RUN 3'h4
`define BPRS_ST_FAULT 3'h5
`endif

// ===== bprs_debounce.v
// Purpose: synchroniser and bounce filter for the external reset request
// Assumes: input idles high through its pull-up
// Notes: output changes only after the input has been stable for the filter time
`include "bprs_consts.vh"
`default_nettype none
module bprs_debounce #(
  parameter [`BPRS_CNT_W-1:0] FILTER_CYCLES = `BPRS_DEBOUNCE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);
  reg sync1_reg;
  reg sync2_reg;
  reg [`BPRS_CNT_W-1:0] cnt_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 1'h1;
      sync2_reg <= 1'h1;
      cnt_reg <= {`BPRS_CNT_W{1'b0}};
      dout <= 1'h1;
    end else begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
      if (sync2_reg == dout) begin
        cnt_reg <= {`BPRS_CNT_W{1'b0}};
      end else if (cnt_reg >= FILTER_CYCLES - 1'b1) begin
        cnt_reg <= {`BPRS_CNT_W{1'b0}};
        dout <= sync2_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bprs_partner.sv
// Purpose: reset key and processor reset wire
// Assumes: key line has a pull-up
// Notes: no bounce modelled
`default_nettype none
module bprs_partner (
  input wire logic PRESS,
  input wire logic CPU_RESET_N_O,
  input wire logic CPU_RESET_N_OE_N,
  output logic EXT_RESET_REQ_N,
  output logic CPU_RESET_WIRE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  assign EXT_RESET_REQ_N = !PRESS;
  assign CPU_RESET_WIRE_N = CPU_RESET_N_OE_N ? 1'h1 : CPU_RESET_N_O;
endmodule
`default_nettype wire

// ===== bprs_seq_asserts.sv
// Purpose: port checks for the sequencer
// Assumes: one clock domain
// Notes: reset length comes from RESET_CYCLES
`default_nettype none
module bprs_asserts #(parameter int RESET_CYCLES = 50) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic POWER_BUTTON_ON,
  input wire logic INPUT_SUPPLY_OK,
  input wire logic MODULE_RAILS_GOOD,
  input wire logic OVERVOLTAGE,
  input wire logic EXT_RESET_REQ_N,
  input wire logic POINT_OF_LOAD_REGULATOR_EN,
  input wire logic CPU_RESET_N_OE_N,
  input wire logic GLOBAL_RESET_OUT_N
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt;
  always_ff @(posedge MCLK) low_cnt <= GLOBAL_RESET_OUT_N ? 0 : low_cnt + 1;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  chk_supply_first: assert property ($rose(POINT_OF_LOAD_REGULATOR_EN) |-> $past(INPUT_SUPPLY_OK))
    else $error("regs on without supply");
  chk_rails_hold: assert property (!MODULE_RAILS_GOOD |=> !GLOBAL_RESET_OUT_N) else $error("rails");
  chk_regs_reset: assert property (!POINT_OF_LOAD_REGULATOR_EN |-> !GLOBAL_RESET_OUT_N) else $error("regs");
  // The counter sees the low level one edge late, but the check samples one edge after the rise, so a full interval reads in full here
  chk_min_reset: assert property ($rose(GLOBAL_RESET_OUT_N) |-> low_cnt >= RESET_CYCLES - 1) else $error("short");
  chk_key_hold: assert property (!EXT_RESET_REQ_N [*8] |-> ##3 !GLOBAL_RESET_OUT_N) else $error("key");
  chk_out_track: assert property (GLOBAL_RESET_OUT_N == CPU_RESET_N_OE_N) else $error("track");
  chk_ov_off: assert property (OVERVOLTAGE |=> !POINT_OF_LOAD_REGULATOR_EN) else $error("ov");
  chk_button_off: assert property (!POWER_BUTTON_ON |=> !POINT_OF_LOAD_REGULATOR_EN) else $error("button");
endmodule
bind bprs_sequencer bprs_asserts #(.RESET_CYCLES(RESET_CYCLES)) chk (.*);
`default_nettype wire

// ===== bprs_sequencer.v
// Purpose: power rail bring-up and system reset sequencing
// Assumes: all inputs synchronous to MCLK except the external reset request
// Notes: a power off or overvoltage drops everything back into reset
`include "bprs_consts.vh"
`default_nettype none
module bprs_sequencer #(
  parameter [`BPRS_CNT_W-1:0] RESET_CYCLES = `BPRS_RESET_CYCLES,
  parameter [`BPRS_CNT_W-1:0] DEBOUNCE_CYCLES = `BPRS_DEBOUNCE_CYCLES
) (
  input wire MCLK,
  input wire RESET_N,
  input wire POWER_BUTTON_ON,
  input wire INPUT_SUPPLY_OK,
  input wire MODULE_RAILS_GOOD,
  input wire OVERVOLTAGE,
  input wire EXT_RESET_REQ_N,
  output reg POINT_OF_LOAD_REGULATOR_EN,
  output reg TRACKING_REGULATOR_EN,
  output reg CPU_RESET_N_O,
  output reg CPU_RESET_N_OE_N,
  output reg GLOBAL_RESET_OUT_N,
  output reg CPU_POWERON_RESET_N,
  output reg STORAGE_RESET_N,
  output reg MEMBANK0_RESET_N,
  output reg MEMBANK1_RESET_N,
  output reg OVERVOLTAGE_FAULT
);
  wire req_n;
  reg req_prev_reg;
  reg [`BPRS_ST_W-1:0] state_reg;
  reg [`BPRS_ST_W-1:0] state_next;
  reg [`BPRS_CNT_W-1:0] cnt_reg;
  reg [`BPRS_CNT_W-1:0] cnt_next;
  reg in_reset;
  reg por_next;
  wire req_fall;

  bprs_debounce #(
    .FILTER_CYCLES(DEBOUNCE_CYCLES)
  ) u_deb (
    .clk(MCLK),
    .rst_n(RESET_N),
    .din(EXT_RESET_REQ_N),
    .dout(req_n)
  );

  assign req_fall = req_prev_reg & ~req_n;

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      `BPRS_ST_OFF: begin
        if (POWER_BUTTON_ON) begin
          state_next = `BPRS_ST_CHECK;
        end
      end
      `BPRS_ST_CHECK: begin
        if (INPUT_SUPPLY_OK) begin
          state_next = `BPRS_ST_RAMP;
        end
      end
      `BPRS_ST_RAMP: begin
        cnt_next = {`BPRS_CNT_W{1'b0}};
        if (MODULE_RAILS_GOOD) begin
          state_next = `BPRS_ST_RESET;
        end
      end
      `BPRS_ST_RESET: begin
        if (!MODULE_RAILS_GOOD) begin
          state_next = `BPRS_ST_RAMP;
        end else if (req_fall) begin
          cnt_next = {`BPRS_CNT_W{1'b0}};
        end else if (cnt_reg < RESET_CYCLES - 1'b1) begin
          cnt_next = cnt_reg + 1'b1;
        end else if (req_n) begin
          state_next = `BPRS_ST_RUN;
        end
      end
      `BPRS_ST_RUN: begin
        if (!MODULE_RAILS_GOOD) begin
          state_next = `BPRS_ST_RAMP;
        end else if (req_fall) begin
          state_next = `BPRS_ST_RESET;
          cnt_next = {`BPRS_CNT_W{1'b0}};
        end
      end
      `BPRS_ST_FAULT: begin
        if (!POWER_BUTTON_ON) begin
          state_next = `BPRS_ST_OFF;
        end
      end
      default: begin
        state_next = `BPRS_ST_OFF;
      end
    endcase
    // Overvoltage outranks everything in any state but OFF; a button cycle is needed to retry
    if (OVERVOLTAGE && state_reg != `BPRS_ST_OFF) begin
      state_next = `BPRS_ST_FAULT;
    end else if (!POWER_BUTTON_ON && state_reg != `BPRS_ST_FAULT) begin
      state_next = `BPRS_ST_OFF;
    end
    in_reset = (state_next != `BPRS_ST_RUN);
    por_next = (state_next == `BPRS_ST_RESET) || (state_next == `BPRS_ST_RUN);
  end

  always @(posedge MCLK) begin
    if (!RESET_N) begin
      state_reg <= `BPRS_ST_OFF;
      cnt_reg <= {`BPRS_CNT_W{1'b0}};
      req_prev_reg <= 1'h1;
      POINT_OF_LOAD_REGULATOR_EN <= 1'h0;
      TRACKING_REGULATOR_EN <= 1'h0;
      CPU_RESET_N_O <= 1'h0;
      CPU_RESET_N_OE_N <= 1'h0;
      GLOBAL_RESET_OUT_N <= 1'h0;
      CPU_POWERON_RESET_N <= 1'h0;
      STORAGE_RESET_N <= 1'h0;
      MEMBANK0_RESET_N <= 1'h0;
      MEMBANK1_RESET_N <= 1'h0;
      OVERVOLTAGE_FAULT <= 1'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      req_prev_reg <= req_n;
      // Regulators on only after the input check has passed
      POINT_OF_LOAD_REGULATOR_EN <= (state_next == `BPRS_ST_RAMP) || por_next;
      TRACKING_REGULATOR_EN <= (state_next == `BPRS_ST_RAMP) || por_next;
      // Open drain: pull low while in reset, release to the pull-up otherwise
      CPU_RESET_N_O <= 1'h0;
      CPU_RESET_N_OE_N <= ~in_reset;
      GLOBAL_RESET_OUT_N <= ~in_reset;
      CPU_POWERON_RESET_N <= por_next;
      STORAGE_RESET_N <= ~in_reset;
      MEMBANK0_RESET_N <= ~in_reset;
      MEMBANK1_RESET_N <= ~in_reset;
      OVERVOLTAGE_FAULT <= (state_next == `BPRS_ST_FAULT);
    end
  end
endmodule
`default_nettype wire
